// ===== hw/hirq_host_if.sv
`timescale 1ns/1ps
module hirq_host_if
  import hirq_pkg::*;
#(
  parameter int GPIO_COUNT = HIRQ_GPIO_COUNT,
  parameter int PEND_WIDTH = HIRQ_PEND_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_report_push,
  input wire logic i_report_read,
  output logic o_report_pending_irq_n_o,
  output logic o_report_pending_irq_n_oe_n,
  output logic [PEND_WIDTH-1:0] o_pending_count,
  input wire logic i_interface_select_strap_i,
  output logic o_interface_select_strap_o,
  output logic o_interface_select_strap_oe_n,
  input wire logic i_core_miso,
  input wire logic i_host_serial_data_i,
  output logic o_host_serial_data_o,
  output logic o_host_serial_data_oe_n,
  input wire logic i_core_sda_drive_low,
  input wire logic i_host_serial_clock_i,
  input wire logic i_bus_address_select_i,
  output logic o_mode_valid,
  output logic o_mode_spi,
  output hirq_i2c_in_type o_i2c,
  output hirq_spi_in_type o_spi,
  input wire logic [GPIO_COUNT-1:0] i_gpio_i,
  output logic [GPIO_COUNT-1:0] o_gpio_o,
  output logic [GPIO_COUNT-1:0] o_gpio_oe_n,
  input wire logic [GPIO_COUNT-1:0] i_gpio_dir_out,
  input wire logic [GPIO_COUNT-1:0] i_gpio_out_val,
  output logic [GPIO_COUNT-1:0] o_gpio_in_val,
  input wire logic i_hsync_enable,
  input wire logic i_vsync_enable,
  output logic o_hsync,
  output logic o_external_frame_sync
);

  initial begin
    if (GPIO_COUNT <= HIRQ_GPIO_VSYNC_BIT || PEND_WIDTH < 1) begin
      $error("hirq_host_if parameters out of range.");
    end
  end

  // ==========================================================================
  // Pin input synchronisers.
  // ==========================================================================
  localparam int SYNC_W = 4 + GPIO_COUNT;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic strap_s;
  logic data_s;
  logic clock_s;
  logic addr_s;
  logic [GPIO_COUNT-1:0] gpio_s;

  assign sync_in = {i_gpio_i, i_bus_address_select_i, i_host_serial_clock_i,
                    i_host_serial_data_i, i_interface_select_strap_i};
  assign strap_s = sync_out[0];
  assign data_s = sync_out[1];
  assign clock_s = sync_out[2];
  assign addr_s = sync_out[3];
  assign gpio_s = sync_out[SYNC_W-1:4];

  hirq_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  // ==========================================================================
  // Strap capture after reset release.
  // ==========================================================================
  typedef enum logic [1:0] {
    HIRQ_ST_SETTLE,
    HIRQ_ST_SAMPLE,
    HIRQ_ST_HOLD
  } hirq_state_type;

  hirq_state_type state_r;
  logic [1:0] settle_r;
  hirq_mode_type mode_r;

  // Waits until the synchroniser holds the real strap level, then latches it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= HIRQ_ST_SETTLE;
      settle_r <= 2'h0;
    end else begin
      case (state_r)
        HIRQ_ST_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == HIRQ_STRAP_SETTLE - 2'h1) begin
            state_r <= HIRQ_ST_SAMPLE;
          end
        end
        HIRQ_ST_SAMPLE: begin
          state_r <= HIRQ_ST_HOLD;
        end
        HIRQ_ST_HOLD: begin
          state_r <= HIRQ_ST_HOLD;
        end
        default: begin
          state_r <= HIRQ_ST_SETTLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= HIRQ_MODE_I2C;
    end else if (state_r == HIRQ_ST_SAMPLE) begin
      mode_r <= (strap_s == HIRQ_STRAP_I2C_LEVEL) ? HIRQ_MODE_I2C : HIRQ_MODE_SPI;
    end
  end

  assign o_mode_valid = (state_r == HIRQ_ST_HOLD);
  assign o_mode_spi = (mode_r == HIRQ_MODE_SPI);

  // ==========================================================================
  // Serial pin routing.
  // ==========================================================================
  logic spi_active;
  logic i2c_active;
  logic miso_r;
  logic sda_low_r;

  assign spi_active = o_mode_valid && (mode_r == HIRQ_MODE_SPI);
  assign i2c_active = o_mode_valid && (mode_r == HIRQ_MODE_I2C);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      miso_r <= 1'h0;
      sda_low_r <= 1'h0;
    end else begin
      miso_r <= i_core_miso;
      sda_low_r <= i2c_active && i_core_sda_drive_low;
    end
  end

  // The strap pin stays an input until SPI is chosen, then drives both levels.
  assign o_interface_select_strap_o = miso_r;
  assign o_interface_select_strap_oe_n = !spi_active;

  // I2C data is open drain; in SPI mode the pin is only an input.
  assign o_host_serial_data_o = 1'h0;
  assign o_host_serial_data_oe_n = !sda_low_r;

  always_comb begin
    o_i2c = '{sda: 1'h1, scl: 1'h1, addr_sel: 1'h0};
    o_spi = '{sck: 1'h0, ss_n: 1'h1, mosi: 1'h0};
    if (i2c_active) begin
      o_i2c.sda = data_s;
      o_i2c.scl = clock_s;
      o_i2c.addr_sel = addr_s;
    end else if (spi_active) begin
      o_spi.sck = data_s;
      o_spi.ss_n = clock_s;
      o_spi.mosi = addr_s;
    end
  end

  // ==========================================================================
  // Report interrupt.
  // ==========================================================================
  logic [PEND_WIDTH-1:0] pend_r;
  logic pend_full;
  logic pend_empty;

  assign pend_full = &pend_r;
  assign pend_empty = (pend_r == '0);

  // A push and a read in the same cycle cancel, except into an empty count, where the push counts; a push into a full count is dropped.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_r <= '0;
    end else if (i_report_push && !pend_full && !(i_report_read && !pend_empty)) begin
      pend_r <= pend_r + 1'b1;
    end else if (i_report_read && !pend_empty && !i_report_push) begin
      pend_r <= pend_r - 1'b1;
    end
  end

  assign o_pending_count = pend_r;
  assign o_report_pending_irq_n_o = 1'h0;
  assign o_report_pending_irq_n_oe_n = pend_empty;

  // ==========================================================================
  // General-purpose pins.
  // ==========================================================================
  logic [GPIO_COUNT-1:0] gpio_out_r;
  logic [GPIO_COUNT-1:0] gpio_oe_n_r;

  generate
    for (genvar g = 0; g < GPIO_COUNT; g++) begin : g_gpio
      logic sync_use;
      assign sync_use = (g == HIRQ_GPIO_HSYNC_BIT && i_hsync_enable) ||
                        (g == HIRQ_GPIO_VSYNC_BIT && i_vsync_enable);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          gpio_out_r[g] <= 1'h0;
          gpio_oe_n_r[g] <= 1'h1;
        end else begin
          gpio_out_r[g] <= i_gpio_out_val[g];
          gpio_oe_n_r[g] <= !(i_gpio_dir_out[g] && !sync_use);
        end
      end
    end
  endgenerate

  assign o_gpio_o = gpio_out_r;
  assign o_gpio_oe_n = gpio_oe_n_r;
  assign o_gpio_in_val = gpio_s;
  assign o_hsync = i_hsync_enable && gpio_s[HIRQ_GPIO_HSYNC_BIT];
  assign o_external_frame_sync = i_vsync_enable && gpio_s[HIRQ_GPIO_VSYNC_BIT];

  // ==========================================================================
  // Checks.
  // ==========================================================================
  property p_irq_low_when_pending;
    @(posedge i_clk) disable iff (!i_rst_n)
      (pend_r != '0) |-> (o_report_pending_irq_n_oe_n == 1'h0);
  endproperty
  a_irq_low_when_pending: assert property (p_irq_low_when_pending)
    else $error("Interrupt released while reports pending.");

  property p_irq_never_high;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_report_pending_irq_n_oe_n == 1'h0) |-> (o_report_pending_irq_n_o == 1'h0);
  endproperty
  a_irq_never_high: assert property (p_irq_never_high)
    else $error("Interrupt pin driven high.");

  property p_read_consumes;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_report_read && !i_report_push && pend_r != '0) |=> (pend_r == $past(pend_r) - 1'b1);
  endproperty
  a_read_consumes: assert property (p_read_consumes)
    else $error("Report read did not consume a report.");

  property p_mode_sampled;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == HIRQ_ST_SAMPLE) |=> (o_mode_spi == $past(strap_s)) && o_mode_valid;
  endproperty
  a_mode_sampled: assert property (p_mode_sampled)
    else $error("Strap level not captured as mode.");

  property p_mode_held;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_mode_valid && $past(o_mode_valid)) |-> $stable(o_mode_spi);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("Mode changed after capture.");

  property p_miso_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_interface_select_strap_oe_n == 1'h0) |-> (spi_active && o_interface_select_strap_o == $past(i_core_miso));
  endproperty
  a_miso_drive: assert property (p_miso_drive)
    else $error("Strap pin driven outside SPI mode or wrong data.");

  property p_sda_spi_input;
    @(posedge i_clk) disable iff (!i_rst_n)
      spi_active ##1 spi_active |-> o_host_serial_data_oe_n && (o_spi.sck == data_s);
  endproperty
  a_sda_spi_input: assert property (p_sda_spi_input)
    else $error("Data pin not an SPI clock input.");

  property p_scl_route;
    @(posedge i_clk) disable iff (!i_rst_n)
      i2c_active |-> (o_i2c.scl == clock_s) && o_spi.ss_n;
  endproperty
  a_scl_route: assert property (p_scl_route)
    else $error("Clock pin misrouted in I2C mode.");

  property p_mosi_route;
    @(posedge i_clk) disable iff (!i_rst_n)
      spi_active |-> (o_spi.mosi == addr_s) && !o_i2c.addr_sel;
  endproperty
  a_mosi_route: assert property (p_mosi_route)
    else $error("Address-select pin not routed to MOSI.");

  property p_sync_input;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_hsync_enable ##1 i_hsync_enable |-> o_gpio_oe_n[HIRQ_GPIO_HSYNC_BIT];
  endproperty
  a_sync_input: assert property (p_sync_input)
    else $error("Sync pin driven while used as input.");

endmodule

// ===== hw/hirq_pkg.sv
package hirq_pkg;

  // ==========================================================================
  // Interface modes and pin layout.
  // ==========================================================================
  typedef enum logic {
    HIRQ_MODE_I2C,
    HIRQ_MODE_SPI
  } hirq_mode_type;

  localparam int HIRQ_GPIO_COUNT = 5;
  localparam int HIRQ_GPIO_HSYNC_BIT = 1;
  localparam int HIRQ_GPIO_VSYNC_BIT = 2;
  localparam int HIRQ_PEND_WIDTH = 8;
  localparam int HIRQ_SYNC_STAGES = 2;
  localparam logic [1:0] HIRQ_STRAP_SETTLE = 2'h2;
  localparam logic HIRQ_STRAP_I2C_LEVEL = 1'h0;

  // ==========================================================================
  // Pin carriers.
  // ==========================================================================
  typedef struct packed {
    logic o;
    logic oe_n;
  } hirq_pin_out_type;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
  } hirq_spi_in_type;

  typedef struct packed {
    logic sda;
    logic scl;
    logic addr_sel;
  } hirq_i2c_in_type;

endpackage

// ===== hw/hirq_sync.sv
`timescale 1ns/1ps
module hirq_sync
  import hirq_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) begin
      $error("hirq_sync WIDTH must be at least 1.");
    end
  end

  // The first stage is read only by the second stage.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ===== test/hirq_host_model.sv
`timescale 1ns/1ps
module hirq_host_model
  import hirq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_irq_n,
  input wire logic i_service,
  input wire logic i_frame,
  input wire logic [7:0] i_byte,
  output logic o_read,
  output hirq_spi_in_type o_spi
);
  // ==========================================================================
  // Report servicing.
  // ==========================================================================
  // One read, then one idle cycle so the line shows the new count before the next look.
  initial o_read = 1'b0;
  always @(posedge i_clk) begin
    o_read <= i_service && (i_irq_n === 1'b0) && !o_read;
  end

  // ==========================================================================
  // Serial master.
  // ==========================================================================
  // The link clock stands still between frames; data is shifted out MSB first.
  initial begin
    o_spi = '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0};
    forever begin
      wait (i_frame);
      #3 o_spi.ss_n = 1'b0;
      for (int k = 7; k >= 0; k--) begin
        o_spi.mosi = i_byte[k];
        #62.5 o_spi.sck = 1'b1;
        #62.5 o_spi.sck = 1'b0;
      end
      #62.5 o_spi.ss_n = 1'b1;
      // A released data line must not keep showing its last bit.
      o_spi.mosi = ~o_spi.mosi;
      wait (!i_frame);
    end
  end
endmodule

// ===== test/hirq_host_if_tb.sv
`timescale 1ns/1ps
module hirq_host_if_tb
  import hirq_pkg::*;
;
  int num_errors = 0;
  int tests_run = 0;

`define CHK(act, exp) \
  begin \
    tests_run++; \
    if ((act) !== (exp)) begin \
      num_errors++; \
      $display("MISMATCH t=%0t act=%0h exp=%0h", $time, (act), (exp)); \
    end \
  end

  // ==========================================================================
  // Stimulus, pins and instances.
  // ==========================================================================
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic push = 1'b0, rd_tb = 1'b0, host_rd, svc = 1'b0, frame = 1'b0, spi_on = 1'b0;
  logic strap_ext = 1'b0, sda_ext = 1'b1, scl_ext = 1'b1, addr_ext = 1'b0;
  logic core_miso = 1'b0, core_sda_low = 1'b0, hs_en = 1'b0, vs_en = 1'b0;
  logic [4:0] gpio_dir = 5'h00, gpio_val = 5'h00, gpio_ext = 5'h1F;
  logic irq_o, irq_oe_n, strap_o, strap_oe_n, sda_o, sda_oe_n;
  logic mode_valid, mode_spi, hsync, xsync;
  logic [7:0] pend_cnt;
  logic [4:0] gpio_o, gpio_oe_n, gpio_in;
  hirq_i2c_in_type i2c;
  hirq_spi_in_type spi, hspi;
  wire irq_pin = irq_oe_n ? 1'b1 : irq_o;
  wire strap_pin = strap_oe_n ? strap_ext : strap_o;
  wire data_pin = spi_on ? hspi.sck : (sda_ext & (sda_oe_n | sda_o));
  wire clk_pin = spi_on ? hspi.ss_n : scl_ext;
  wire addr_pin = spi_on ? hspi.mosi : addr_ext;
  wire [4:0] gpio_pin = (gpio_oe_n & gpio_ext) | (~gpio_oe_n & gpio_o);

  always #5 clk = ~clk;

  hirq_host_if hirq_host_if_i (
    .i_clk(clk),
    .i_rst_n(rst_n),
    .i_report_push(push),
    .i_report_read(rd_tb | host_rd),
    .o_report_pending_irq_n_o(irq_o),
    .o_report_pending_irq_n_oe_n(irq_oe_n),
    .o_pending_count(pend_cnt),
    .i_interface_select_strap_i(strap_pin),
    .o_interface_select_strap_o(strap_o),
    .o_interface_select_strap_oe_n(strap_oe_n),
    .i_core_miso(core_miso),
    .i_host_serial_data_i(data_pin),
    .o_host_serial_data_o(sda_o),
    .o_host_serial_data_oe_n(sda_oe_n),
    .i_core_sda_drive_low(core_sda_low),
    .i_host_serial_clock_i(clk_pin),
    .i_bus_address_select_i(addr_pin),
    .o_mode_valid(mode_valid),
    .o_mode_spi(mode_spi),
    .o_i2c(i2c),
    .o_spi(spi),
    .i_gpio_i(gpio_pin),
    .o_gpio_o(gpio_o),
    .o_gpio_oe_n(gpio_oe_n),
    .i_gpio_dir_out(gpio_dir),
    .i_gpio_out_val(gpio_val),
    .o_gpio_in_val(gpio_in),
    .i_hsync_enable(hs_en),
    .i_vsync_enable(vs_en),
    .o_hsync(hsync),
    .o_external_frame_sync(xsync)
  );

  hirq_host_model hirq_host_model_i (
    .i_clk(clk),
    .i_irq_n(irq_pin),
    .i_service(svc),
    .i_frame(frame),
    .i_byte(8'hA5),
    .o_read(host_rd),
    .o_spi(hspi)
  );

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timed_out;
    num_errors++;
    wrap_up();
  endtask

  // Waits for edges, then lets that edge's updates land before anything is looked at.
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic lvl);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    strap_ext <= lvl;
    spi_on <= lvl;
    look(3);
    `CHK({irq_oe_n, strap_oe_n, sda_oe_n, mode_valid, pend_cnt}, 12'hE00)
    repeat (9) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 10 && mode_valid !== 1'b1; n++) look(1);
    if (n == 10) timed_out();
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_i2c_mode;
    `CHK({mode_spi, strap_oe_n}, 2'b01)
    @(posedge clk);
    strap_ext <= 1'b1;
    sda_ext <= 1'b0;
    scl_ext <= 1'b0;
    addr_ext <= 1'b1;
    look(4);
    `CHK(mode_spi, 1'b0)
    `CHK({i2c, spi}, 6'b001010)
    @(posedge clk);
    core_sda_low <= 1'b1;
    sda_ext <= 1'b1;
    look(2);
    `CHK({sda_oe_n, sda_o}, 2'b00)
    @(posedge clk);
    core_sda_low <= 1'b0;
    addr_ext <= 1'b0;
    look(4);
    `CHK({sda_oe_n, i2c}, 4'b1100)
  endtask

  task automatic t_reports;
    int n;
    @(posedge clk);
    push <= 1'b1;
    repeat (3) @(posedge clk);
    push <= 1'b0;
    look(1);
    `CHK({pend_cnt, irq_pin, irq_o}, 10'h00C)
    @(posedge clk);
    push <= 1'b1;
    rd_tb <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    rd_tb <= 1'b0;
    look(1);
    `CHK(pend_cnt, 8'h03)
    @(posedge clk);
    svc <= 1'b1;
    for (n = 0; n < 20 && pend_cnt !== 8'h00; n++) begin
      `CHK(irq_pin, 1'b0)
      look(1);
    end
    if (n == 20) timed_out();
    `CHK({irq_oe_n, irq_o, irq_pin}, 3'b101)
    @(posedge clk);
    svc <= 1'b0;
    rd_tb <= 1'b1;
    @(posedge clk);
    rd_tb <= 1'b0;
    look(1);
    `CHK({pend_cnt, irq_oe_n}, 9'h001)
  endtask

  task automatic t_gpio;
    @(posedge clk);
    gpio_dir <= 5'h11;
    gpio_val <= 5'h10;
    gpio_ext <= 5'h0A;
    look(4);
    `CHK({gpio_oe_n, gpio_o[4], gpio_o[0]}, 7'h3A)
    `CHK({gpio_in, hsync, xsync}, 7'h68)
    @(posedge clk);
    gpio_dir <= 5'h1F;
    hs_en <= 1'b1;
    vs_en <= 1'b1;
    gpio_ext <= 5'h06;
    look(4);
    `CHK({gpio_oe_n[2:1], hsync, xsync}, 4'hF)
    @(posedge clk);
    gpio_ext <= 5'h00;
    look(4);
    `CHK({hsync, xsync}, 2'b00)
  endtask

  task automatic t_spi_mode;
    int n;
    int bits;
    logic [7:0] got;
    logic prev;
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    do_reset(1'b1);
    `CHK({mode_valid, mode_spi, strap_oe_n, i2c}, 6'b110110)
    @(posedge clk);
    core_miso <= 1'b1;
    look(2);
    `CHK(strap_pin, 1'b1)
    @(posedge clk);
    core_miso <= 1'b0;
    frame <= 1'b1;
    look(2);
    `CHK(strap_pin, 1'b0)
    bits = 0;
    prev = 1'b0;
    got = 8'h00;
    for (n = 0; n < 400 && bits < 8; n++) begin
      look(1);
      if (!prev && spi.sck === 1'b1) begin
        got = {got[6:0], spi.mosi};
        bits++;
        `CHK(spi.ss_n, 1'b0)
      end
      prev = spi.sck;
    end
    if (bits < 8) timed_out();
    @(posedge clk);
    frame <= 1'b0;
    `CHK(got, 8'hA5)
    // After the frame the select rises and the data line shows the inverse of the last bit.
    look(16);
    `CHK({spi.ss_n, spi.mosi}, 2'b10)
  endtask

  initial begin
    do_reset(1'b0);
    t_i2c_mode();
    t_reports();
    t_gpio();
    t_spi_mode();
    wrap_up();
  end
endmodule
